// >>> logic/spi_reg_port.sv
// Device end: SPI slave that gives an external master access to the register file.
`timescale 1ns/10ps
`default_nettype none
`include "spi_port_defs.svh"

module spi_reg_port
	import spi_port_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic reset,
	// Serial link.
	spi_link_if.device link,
	// Peripheral mode status.
	input wire logic suspend_event,
	input wire logic bus_reset_event,
	input wire logic setup_avail_event,
	input wire logic ep3_in_buf_avail,
	input wire logic ep2_in_buf_avail,
	input wire logic ep1_out_data_avail,
	input wire logic ep0_out_data_avail,
	input wire logic ep0_in_buf_avail,
	// Host mode status.
	input wire logic host_xfer_done_event,
	input wire logic frame_event,
	input wire logic connect_event,
	input wire logic suspend_done_event,
	input wire logic send_buf_avail,
	input wire logic recv_data_avail,
	input wire logic resume_request_event,
	input wire logic bus_event_flag,
	// Register read side.
	output logic [4:0] rd_addr,
	input wire logic [7:0] rd_data,
	output logic rd_pop,
	// Register write side.
	output logic [4:0] wr_addr,
	output logic [7:0] wr_data,
	output logic wr_en,
	// Side effects and mode.
	output logic ack_set,
	output logic host_mode,
	output logic full_duplex
);

	typedef struct packed {
		logic [2:0] sclk_p;
		logic [2:0] ss_p;
		logic [1:0] mosi_p;
		dev_state_e st;
		logic [2:0] bit_n;
		logic [7:0] rx;
		logic [7:0] tx;
		logic [4:0] addr;
		logic dir;
		logic host;
		logic fdup;
		logic dout;
		logic miso_oe;
		logic mosi_oe;
		logic [4:0] wr_addr;
		logic [7:0] wr_data;
		logic wr_en;
		logic rd_pop;
		logic ack_set;
	} dev_s;

	dev_s q;
	dev_s d;
	logic [7:0] byte_in;
	logic [7:0] status;
	logic [7:0] rd_masked;
	logic rise;
	logic fall;

	// Address walk after each data byte.
	function automatic logic [4:0] next_addr(input logic [4:0] a);
		logic [4:0] n;
		n = a + `REG_STEP;
		if (a <= `REG_FIFO_LAST) begin
			n = a;
		end else if (a == `REG_HOLD_A || a == `REG_HOLD_B) begin
			n = a;
		end
		return n;
	endfunction

	// Bits that do not apply to the current mode read as zero.
	function automatic logic [7:0] read_mask(input logic [4:0] a, input logic h,
			input logic [7:0] v);
		logic [7:0] r;
		r = v;
		if (a == `REG_MODE) begin
			r = {v[7:1], h} & `MODE_USED_MASK;
		end else if (!h) begin
			if (a == `REG_P_RSV_A || a == `REG_P_RSV_B || a >= `REG_P_RSV_HI) begin
				r = 8'h00;
			end
		end else begin
			if (a == `REG_H_RSV_0 || a == `REG_H_RSV_3 || a == `REG_H_RSV_5 ||
					(a >= `REG_H_RSV_LO && a <= `REG_H_RSV_HI)) begin
				r = 8'h00;
			end
		end
		return r;
	endfunction

	// Edges are taken from the second and third stages only.
	assign rise = q.sclk_p[1] & ~q.sclk_p[2];
	assign fall = ~q.sclk_p[1] & q.sclk_p[2];
	assign byte_in = {q.rx[6:0], q.mosi_p[1]};
	assign rd_masked = read_mask(q.addr, q.host, rd_data);

	always_comb begin
		if (q.host) begin
			status = {host_xfer_done_event, frame_event, connect_event,
				suspend_done_event, send_buf_avail, recv_data_avail,
				resume_request_event, bus_event_flag};
		end else begin
			status = {suspend_event, bus_reset_event, setup_avail_event,
				ep3_in_buf_avail, ep2_in_buf_avail, ep1_out_data_avail,
				ep0_out_data_avail, ep0_in_buf_avail};
		end
	end

	always_comb begin
		d = q;
		d.wr_en = 1'b0;
		d.rd_pop = 1'b0;
		d.ack_set = 1'b0;
		d.sclk_p = {q.sclk_p[1:0], link.sclk};
		d.ss_p = {q.ss_p[1:0], link.ss_n};
		d.mosi_p = {q.mosi_p[0], link.mosi_line};
		if (q.ss_p[1]) begin
			// Deselected: clock ignored, both data drivers off.
			d.st = DEV_IDLE;
			d.miso_oe = 1'b0;
			d.mosi_oe = 1'b0;
			d.dout = 1'b0;
		end else if (q.ss_p[2]) begin
			// New frame always starts with a command byte.
			d.st = DEV_CMD;
			d.bit_n = `BIT_FIRST;
			d.mosi_oe = 1'b0;
			d.miso_oe = q.fdup;
			if (q.fdup) begin
				d.dout = status[7];
				d.tx = {status[6:0], 1'b0};
			end else begin
				d.dout = 1'b0;
				d.tx = 8'h00;
			end
		end else if (rise && q.st != DEV_IDLE) begin
			d.rx = byte_in;
			d.bit_n = q.bit_n + `BIT_STEP;
			if (q.bit_n == `BIT_LAST) begin
				if (q.st == DEV_CMD) begin
					d.addr = byte_in[`CMD_ADDR_HI:`CMD_ADDR_LO];
					d.dir = byte_in[`CMD_DIR_BIT];
					d.ack_set = byte_in[`CMD_ACK_BIT] & ~q.host;
					d.st = DEV_DATA;
				end else begin
					if (q.dir == `CMD_DIR_WRITE) begin
						d.wr_en = 1'b1;
						d.wr_addr = q.addr;
						d.wr_data = byte_in;
						if (q.addr == `REG_MODE) begin
							d.host = byte_in[`MODE_HOST_BIT];
						end
						if (q.addr == `REG_PINCTL) begin
							d.fdup = byte_in[`PINCTL_FDUP_BIT];
						end
					end else begin
						d.rd_pop = 1'b1;
					end
					d.addr = next_addr(q.addr);
				end
			end
		end else if (fall && q.st != DEV_IDLE) begin
			d.dout = q.tx[7];
			d.tx = {q.tx[6:0], 1'b0};
			if (q.st == DEV_DATA && q.bit_n == `BIT_FIRST) begin
				d.miso_oe = q.fdup;
				d.mosi_oe = ~q.fdup & (q.dir != `CMD_DIR_WRITE);
				if (q.dir != `CMD_DIR_WRITE) begin
					d.dout = rd_masked[7];
					d.tx = {rd_masked[6:0], 1'b0};
				end else begin
					d.dout = 1'b0;
					d.tx = 8'h00;
				end
			end
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			q <= '{sclk_p: 3'h0, ss_p: 3'h7, mosi_p: 2'h3, st: DEV_IDLE,
				bit_n: 3'h0, rx: 8'h00, tx: 8'h00, addr: 5'h00, dir: 1'b0,
				host: 1'b0, fdup: 1'b0, dout: 1'b0, miso_oe: 1'b0,
				mosi_oe: 1'b0, wr_addr: 5'h00, wr_data: 8'h00, wr_en: 1'b0,
				rd_pop: 1'b0, ack_set: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign link.miso_o = q.dout;
	assign link.miso_oe = q.miso_oe;
	assign link.mosi_d_o = q.dout;
	assign link.mosi_d_oe = q.mosi_oe;
	assign rd_addr = q.addr;
	assign rd_pop = q.rd_pop;
	assign wr_addr = q.wr_addr;
	assign wr_data = q.wr_data;
	assign wr_en = q.wr_en;
	assign ack_set = q.ack_set;
	assign host_mode = q.host;
	assign full_duplex = q.fdup;

endmodule

`default_nettype wire

// >>> logic/spi_port_defs.svh
// Shared constants for the SPI register access port.
`ifndef SPI_PORT_DEFS_SVH
`define SPI_PORT_DEFS_SVH

// Command byte layout.
`define CMD_ADDR_HI 7
`define CMD_ADDR_LO 3
`define CMD_ZERO_BIT 2
`define CMD_DIR_BIT 1
`define CMD_ACK_BIT 0
`define CMD_DIR_WRITE 1'b1

// Bit counter within a byte.
`define BIT_FIRST 3'h0
`define BIT_LAST 3'h7
`define BIT_STEP 3'h1

// Register numbers that steer the address walk.
`define REG_FIFO_LAST 5'h04
`define REG_HOLD_A 5'h14
`define REG_HOLD_B 5'h1F
`define REG_STEP 5'h01

// Registers snooped by the port.
`define REG_PINCTL 5'h11
`define PINCTL_FDUP_BIT 4
`define REG_MODE 5'h1B
`define MODE_HOST_BIT 0
`define MODE_USED_MASK 8'h11

// Registers that read as zero in peripheral mode.
`define REG_P_RSV_A 5'h19
`define REG_P_RSV_B 5'h1A
`define REG_P_RSV_HI 5'h1C

// Registers that read as zero in host mode.
`define REG_H_RSV_0 5'h00
`define REG_H_RSV_3 5'h03
`define REG_H_RSV_5 5'h05
`define REG_H_RSV_LO 5'h08
`define REG_H_RSV_HI 5'h0C

// Serial clock half period of the master, in core clock cycles.
`define SCLK_HALF_CYC 8'h08

`endif

// >>> logic/spi_port_pkg.sv
// Types shared by both ends of the SPI register access port.
package spi_port_pkg;

	typedef enum logic [2:0] {
		DEV_IDLE = 3'b001,
		DEV_CMD = 3'b010,
		DEV_DATA = 3'b100
	} dev_state_e;

	typedef enum logic [2:0] {
		MST_IDLE = 3'b001,
		MST_SHIFT = 3'b010,
		MST_STOP = 3'b100
	} mst_state_e;

endpackage

// >>> logic/spi_link_if.sv
// Serial link between the SPI master and the register access port.
`timescale 1ns/10ps
`default_nettype none

interface spi_link_if;
	logic sclk;
	logic ss_n;
	logic mosi_m_o;
	logic mosi_m_oe;
	logic mosi_d_o;
	logic mosi_d_oe;
	logic miso_o;
	logic miso_oe;
	logic mosi_line;
	logic miso_line;

	// Wire levels; an undriven line rests high.
	assign mosi_line = mosi_d_oe ? mosi_d_o : (mosi_m_oe ? mosi_m_o : 1'b1);
	assign miso_line = miso_oe ? miso_o : 1'b1;

	modport master (
		output sclk,
		output ss_n,
		output mosi_m_o,
		output mosi_m_oe,
		input mosi_line,
		input miso_line
	);

	modport device (
		input sclk,
		input ss_n,
		input mosi_line,
		output mosi_d_o,
		output mosi_d_oe,
		output miso_o,
		output miso_oe
	);
endinterface

`default_nettype wire

// >>> logic/spi_reg_master.sv
// Master end: drives select, serial clock and data to reach the register port.
`timescale 1ns/10ps
`default_nettype none
`include "spi_port_defs.svh"

module spi_reg_master
	import spi_port_pkg::*;
#(
	parameter logic [7:0] HALF_CYC = `SCLK_HALF_CYC
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset,
	// Serial link.
	spi_link_if.master link,
	// Transfer request.
	input wire logic start,
	input wire logic [4:0] cmd_addr,
	input wire logic cmd_dir,
	input wire logic cmd_ack,
	input wire logic [7:0] data_count,
	input wire logic half_duplex,
	// Write data.
	input wire logic [7:0] tx_data,
	output logic tx_take,
	// Read data and progress.
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic busy,
	output logic done
);

	typedef struct packed {
		mst_state_e st;
		logic [7:0] cnt;
		logic sclk;
		logic ss_n;
		logic mosi_o;
		logic mosi_oe;
		logic [7:0] tx;
		logic [7:0] rx;
		logic [2:0] bit_n;
		logic [7:0] left;
		logic first;
		logic dir;
		logic half;
		logic [1:0] miso_p;
		logic [1:0] line_p;
		logic [7:0] rx_data;
		logic rx_valid;
		logic tx_take;
		logic busy;
		logic done;
	} mst_s;

	mst_s q;
	mst_s d;
	logic [7:0] cmd_byte;
	logic tick;
	logic in_bit;

	assign cmd_byte = {cmd_addr, 1'b0, cmd_dir, cmd_ack};
	assign tick = (q.cnt == HALF_CYC - 8'h01);
	// Half-duplex read data returns on the shared data line.
	assign in_bit = (q.half && !q.first && q.dir != `CMD_DIR_WRITE) ?
		q.line_p[1] : q.miso_p[1];

	always_comb begin
		d = q;
		d.rx_valid = 1'b0;
		d.tx_take = 1'b0;
		d.done = 1'b0;
		d.miso_p = {q.miso_p[0], link.miso_line};
		d.line_p = {q.line_p[0], link.mosi_line};
		d.cnt = tick ? 8'h00 : q.cnt + 8'h01;
		case (q.st)
			MST_IDLE: begin
				d.cnt = 8'h00;
				if (start) begin
					d.st = MST_SHIFT;
					d.ss_n = 1'b0;
					d.mosi_oe = 1'b1;
					d.mosi_o = cmd_byte[7];
					d.tx = {cmd_byte[6:0], 1'b0};
					d.bit_n = `BIT_FIRST;
					d.left = data_count;
					d.first = 1'b1;
					d.dir = cmd_dir;
					d.half = half_duplex;
					d.busy = 1'b1;
				end
			end
			MST_SHIFT: begin
				if (tick) begin
					d.sclk = ~q.sclk;
					if (!q.sclk) begin
						d.rx = {q.rx[6:0], in_bit};
						d.bit_n = q.bit_n + `BIT_STEP;
						if (q.bit_n == `BIT_LAST) begin
							d.rx_data = {q.rx[6:0], in_bit};
							d.rx_valid = 1'b1;
							d.first = 1'b0;
							if (q.left == 8'h00) begin
								d.st = MST_STOP;
							end else begin
								d.left = q.left - 8'h01;
							end
						end
					end else if (q.bit_n == `BIT_FIRST) begin
						if (q.dir == `CMD_DIR_WRITE) begin
							d.tx_take = 1'b1;
							d.mosi_oe = 1'b1;
							d.mosi_o = tx_data[7];
							d.tx = {tx_data[6:0], 1'b0};
						end else begin
							d.mosi_oe = ~q.half;
							d.mosi_o = 1'b0;
							d.tx = 8'h00;
						end
					end else begin
						d.mosi_o = q.tx[7];
						d.tx = {q.tx[6:0], 1'b0};
					end
				end
			end
			MST_STOP: begin
				if (tick) begin
					if (q.sclk) begin
						d.sclk = 1'b0;
					end else begin
						d.st = MST_IDLE;
						d.ss_n = 1'b1;
						d.mosi_oe = 1'b0;
						d.busy = 1'b0;
						d.done = 1'b1;
					end
				end
			end
			default: begin
				d.st = MST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			q <= '{st: MST_IDLE, cnt: 8'h00, sclk: 1'b0, ss_n: 1'b1, mosi_o: 1'b0,
				mosi_oe: 1'b0, tx: 8'h00, rx: 8'h00, bit_n: 3'h0, left: 8'h00,
				first: 1'b0, dir: 1'b0, half: 1'b0, miso_p: 2'h3, line_p: 2'h3,
				rx_data: 8'h00, rx_valid: 1'b0, tx_take: 1'b0, busy: 1'b0,
				done: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign link.sclk = q.sclk;
	assign link.ss_n = q.ss_n;
	assign link.mosi_m_o = q.mosi_o;
	assign link.mosi_m_oe = q.mosi_oe;
	assign tx_take = q.tx_take;
	assign rx_data = q.rx_data;
	assign rx_valid = q.rx_valid;
	assign busy = q.busy;
	assign done = q.done;

endmodule

`default_nettype wire

// >>> tb/spi_link_properties.sv
// Link checker for the SPI register access port.
`timescale 1ns/10ps
`default_nettype none

module spi_link_properties (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset,
	// Link signals.
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi_m_o,
	input wire logic mosi_m_oe,
	input wire logic mosi_d_o,
	input wire logic mosi_d_oe,
	input wire logic miso_o,
	input wire logic miso_oe
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	sequence s_released;
		!miso_oe && !mosi_d_oe;
	endsequence

	// The master runs with its default half period of eight cycles.
	sequence s_high_phase;
		sclk [*8] ##1 !sclk;
	endsequence

	chk_end_release:
	assert property ($rose(ss_n) |-> ##3 s_released) else $error("outputs kept after deselect");
	chk_idle_float:
	assert property (ss_n [*5] |-> s_released) else $error("output driven while idle");
	chk_select_sclk:
	assert property ($fell(ss_n) |-> !sclk) else $error("sclk high at select");
	chk_idle_sclk:
	assert property (ss_n |-> !sclk) else $error("sclk high while idle");
	chk_sclk_high:
	assert property ($rose(sclk) |-> s_high_phase) else $error("sclk high phase length");
	chk_miso_stable:
	assert property (sclk && $past(sclk) && miso_oe |-> $stable(miso_o))
		else $error("miso moved while sclk high");
	chk_mosi_dev_stable:
	assert property (sclk && $past(sclk) && mosi_d_oe |-> $stable(mosi_d_o))
		else $error("device data moved while sclk high");
	chk_master_edge:
	assert property (!ss_n && mosi_m_oe && $past(mosi_m_oe) && $changed(mosi_m_o)
		|-> $fell(sclk)) else $error("master data moved off falling edge");
	chk_no_contend:
	assert property (!(mosi_d_oe && mosi_m_oe)) else $error("both ends drive mosi");
	chk_one_output:
	assert property (!(miso_oe && mosi_d_oe)) else $error("device drives both lines");
endmodule

`default_nettype wire

// >>> tb/tb_spi_register_access_port.sv
// Testbench joining both ends of the SPI register access port.
`timescale 1ns/10ps
`default_nettype none

module tb_spi_register_access_port;
	typedef struct packed {
		logic [4:0] a;
		logic [7:0] n;
		logic [4:0] last;
	} row_s;

	logic clock = 1'b0;
	logic reset = 1'b1;
	logic start = 1'b0;
	logic hd = 1'b1;
	logic cmd_dir = 1'b0;
	logic cmd_ack = 1'b0;
	logic [4:0] cmd_addr = 5'h00;
	logic [4:0] wa = 5'h00;
	logic [7:0] data_count = 8'h00;
	logic [7:0] tx_base = 8'h00;
	logic [7:0] tx_idx = 8'h00;
	logic [7:0] pst = 8'h00;
	logic [7:0] hst = 8'h00;
	logic [7:0] n_wr = 8'h00;
	logic [7:0] n_pop = 8'h00;
	logic [7:0] n_ack = 8'h00;
	logic [7:0] wd = 8'h00;
	logic [4:0] rd_addr, wr_addr;
	logic [7:0] rd_data, wr_data, tx_data, rx_data;
	logic rd_pop, wr_en, ack_set, host_mode, full_duplex, tx_take, rx_valid, busy, done;
	logic [7:0] rxq[$];
	int num_errors = 0;
	int comparisons = 0;
	row_s rows[6] = '{'{5'h02, 8'h03, 5'h02}, '{5'h12, 8'h03, 5'h14}, '{5'h13, 8'h03, 5'h14},
		'{5'h14, 8'h02, 5'h14}, '{5'h1D, 8'h04, 5'h1F}, '{5'h05, 8'h02, 5'h06}};

	always #5 clock = ~clock;

	// Register file model: each register reads as its own number with a marker.
	assign rd_data = {3'h2, rd_addr};
	assign tx_data = tx_base + tx_idx;

	spi_link_if i_spi_link_if ();

	spi_reg_master i_spi_reg_master (.clock(clock), .reset(reset), .link(i_spi_link_if),
		.start(start), .cmd_addr(cmd_addr), .cmd_dir(cmd_dir), .cmd_ack(cmd_ack),
		.data_count(data_count), .half_duplex(hd), .tx_data(tx_data), .tx_take(tx_take),
		.rx_data(rx_data), .rx_valid(rx_valid), .busy(busy), .done(done));

	spi_reg_port i_spi_reg_port (.clock(clock), .reset(reset), .link(i_spi_link_if),
		.suspend_event(pst[7]), .bus_reset_event(pst[6]), .setup_avail_event(pst[5]),
		.ep3_in_buf_avail(pst[4]), .ep2_in_buf_avail(pst[3]), .ep1_out_data_avail(pst[2]),
		.ep0_out_data_avail(pst[1]), .ep0_in_buf_avail(pst[0]),
		.host_xfer_done_event(hst[7]), .frame_event(hst[6]), .connect_event(hst[5]),
		.suspend_done_event(hst[4]), .send_buf_avail(hst[3]), .recv_data_avail(hst[2]),
		.resume_request_event(hst[1]), .bus_event_flag(hst[0]),
		.rd_addr(rd_addr), .rd_data(rd_data), .rd_pop(rd_pop), .wr_addr(wr_addr),
		.wr_data(wr_data), .wr_en(wr_en), .ack_set(ack_set), .host_mode(host_mode),
		.full_duplex(full_duplex));

	spi_link_properties i_spi_link_properties (.clock(clock), .reset(reset),
		.sclk(i_spi_link_if.sclk), .ss_n(i_spi_link_if.ss_n),
		.mosi_m_o(i_spi_link_if.mosi_m_o), .mosi_m_oe(i_spi_link_if.mosi_m_oe),
		.mosi_d_o(i_spi_link_if.mosi_d_o), .mosi_d_oe(i_spi_link_if.mosi_d_oe),
		.miso_o(i_spi_link_if.miso_o), .miso_oe(i_spi_link_if.miso_oe));

	// Counts what the port does during one transfer.
	always @(posedge clock) begin
		if (done) begin
			tx_idx <= 8'h00;
		end else if (tx_take) begin
			tx_idx <= tx_idx + 8'h01;
		end
		if (start) begin
			n_wr <= 8'h00;
			n_pop <= 8'h00;
			n_ack <= 8'h00;
			rxq.delete();
		end else begin
			if (wr_en) begin
				n_wr <= n_wr + 8'h01;
				wa <= wr_addr;
				wd <= wr_data;
			end
			if (rd_pop) n_pop <= n_pop + 8'h01;
			if (ack_set) n_ack <= n_ack + 8'h01;
			if (rx_valid) rxq.push_back(rx_data);
		end
	end

	task chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task finish_test;
		$display("Checked %0d values, %0d errors", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic xfer(input logic [4:0] a, input logic d, k, input logic [7:0] n, b);
		start <= 1'b1;
		cmd_addr <= a;
		cmd_dir <= d;
		cmd_ack <= k;
		data_count <= n;
		tx_base <= b;
		@(posedge clock);
		start <= 1'b0;
		@(posedge clock);
		chk_val("busy", 8'h01, {7'h00, busy});
		repeat (4000) begin
			@(posedge clock);
			if (done === 1'b1) break;
		end
		// A transfer that never ends shows up here as a missing done pulse.
		chk_val("done", 8'h01, {7'h00, done});
		chk_val("busy", 8'h00, {7'h00, busy});
		repeat (4) @(posedge clock);
	endtask

	task automatic rd(input logic [4:0] a, input logic k, input logic [7:0] st,
		input logic [7:0] e[$]);
		xfer(a, 1'b0, k, 8'(e.size()), 8'h00);
		chk_val("rx count", 8'(e.size() + 1), 8'(rxq.size()));
		chk_val("status", st, rxq[0]);
		foreach (e[i]) chk_val("rd_data", e[i], rxq[i + 1]);
		chk_val("pops", 8'(e.size()), n_pop);
	endtask

	initial begin
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		chk_val("host_mode", 8'h00, {7'h00, host_mode});
		foreach (rows[i]) begin
			xfer(rows[i].a, 1'b1, 1'b0, rows[i].n, 8'h81 + 8'(i * 16));
			chk_val("writes", rows[i].n, n_wr);
			chk_val("wr_addr", {3'h0, rows[i].last}, {3'h0, wa});
			chk_val("wr_data", 8'h80 + 8'(i * 16) + rows[i].n, wd);
			chk_val("pops", 8'h00, n_pop);
		end
		// In half duplex the released data output rests high during the command byte.
		rd(5'h03, 1'b0, 8'hFF, {8'h43, 8'h43});
		rd(5'h1D, 1'b0, 8'hFF, {8'h00, 8'h00, 8'h00, 8'h00});
		xfer(5'h11, 1'b1, 1'b0, 8'h01, 8'h10);
		chk_val("full_duplex", 8'h01, {7'h00, full_duplex});
		hd <= 1'b0;
		pst <= 8'hA5;
		hst <= 8'h3C;
		rd(5'h1A, 1'b0, 8'hA5, {8'h00, 8'h10, 8'h00});
		xfer(5'h09, 1'b0, 1'b1, 8'h00, 8'h00);
		chk_val("ack_set", 8'h01, n_ack);
		xfer(5'h1B, 1'b1, 1'b0, 8'h01, 8'h01);
		chk_val("host_mode", 8'h01, {7'h00, host_mode});
		rd(5'h04, 1'b1, 8'h3C, {8'h44, 8'h44});
		chk_val("ack_set", 8'h00, n_ack);
		rd(5'h0B, 1'b0, 8'h3C, {8'h00, 8'h00});
		rd(5'h1B, 1'b0, 8'h3C, {8'h11});
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		hd <= 1'b1;
		@(posedge clock);
		chk_val("host_mode", 8'h00, {7'h00, host_mode});
		chk_val("full_duplex", 8'h00, {7'h00, full_duplex});
		rd(5'h06, 1'b0, 8'hFF, {8'h46, 8'h47});
		finish_test();
	end

	initial begin
		#400000;
		num_errors++;
		finish_test();
	end
endmodule

`default_nettype wire
